// ---- design/exc_pkg.sv ----
package exc_pkg;

    // Register byte addresses (chosen; no offsets printed)
    localparam logic [7:0] ADDR_BREAK_WAIT = 8'h00;
    localparam logic [7:0] ADDR_RESET_SRC = 8'h04;
    localparam logic [7:0] ADDR_BREAK_CTRL = 8'h08;
    localparam logic [7:0] ADDR_CONFIG = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;

    // Field positions
    localparam int BIT_BRK_WAIT = 0;
    localparam int BIT_CLR_EN = 7;
    localparam int BIT_SHORT_WAKE = 0;
    localparam int BIT_WDOG_OFF = 1;
    localparam int RS_POR = 7;
    localparam int RS_PIN = 6;
    localparam int RS_WDOG = 5;
    localparam int RS_BAD_OP = 4;
    localparam int RS_BAD_ADDR = 3;
    localparam int RS_LOW_VDD = 1;

    localparam int NUM_IRQ = 8;
    localparam logic [2:0] IRQ_NONE_IDX = 3'h0;
    localparam logic [3:0] VEC_TRAP = 4'hF;
    localparam logic [3:0] VEC_IDLE = 4'h0;

    // Stop recovery counts in crystal cycles
    localparam int STOP_LONG_CYC = 4096;
    localparam int STOP_SHORT_CYC = 32;
    localparam logic [11:0] CNT_LONG_LAST = 12'hFFF;
    localparam logic [11:0] CNT_SHORT_LAST = 12'h01F;
    localparam logic [11:0] CNT_ZERO = 12'h000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] PC_ONE = 16'h0001;

    typedef enum logic [2:0] {
        RUN,
        WAITING,
        STOPPED,
        RECOVER,
        STACKING
    } mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic sel;
    } bus_phase_type;

    typedef struct packed {
        logic por;
        logic pin;
        logic wdog;
        logic bad_op;
        logic bad_addr;
        logic low_vdd;
    } reset_src_type;

    typedef struct packed {
        mode_type mode;
        logic latched;
        logic [2:0] latched_idx;
        logic trap;
        logic break_state;
        logic break_exit_wait_flag;
        logic break_flag_clear_enable;
        logic short_wake_delay_bit;
        logic watchdog_disable_bit;
        logic [7:0] rsr;
        logic [11:0] cnt;
        logic cnt_hold;
        bus_phase_type ph;
        logic [31:0] rdata;
        logic [3:0] vector;
        logic [15:0] ret_pc;
        logic push;
        logic set_mask;
        logic clr_mask;
    } state_type;

endpackage

// ---- design/system_exception_power_control.sv ----
// Contract
// (RULE1) Latched interrupt holds until serviced or unmasked
// (RULE2) Interrupts taken only at instruction boundaries
// (RULE3) Highest priority pending serviced first
// (RULE4) Entry stacks registers and sets mask
// (RULE5) Upper index register never stacked
// (RULE6) Software trap ignores interrupt mask
// (RULE7) Trap stacks PC; hardware stacks PC-1
// (RULE8) Resets beat all interrupts, skip arbitration
// (RULE9) Break forces software trap vector
// (RULE10) Break protects flags unless clear enabled
// (RULE11) Flag cleared in break stays cleared
// (RULE12) Two-step clears protected across break entry
// (RULE13) Wait and stop clear interrupt mask
// (RULE14) Wait gates core clock, interrupt wakes
// (RULE15) Break wakes wait and sets break-wait bit
// (RULE16) Watchdog runs in wait unless disabled
// (RULE17) Stop resets counter, disables both clocks
// (RULE18) Stop recovery 4096 or 32 cycles
// (RULE19) Counter held until recovery, then counts
// (RULE20) Break inactive in stop, registers kept
// (RULE21) Break-wait bit cleared by zero write, reset
// (RULE22) Reset status read-clear, power-on clears others
// (RULE23) Recovery counter twelve bits, crystal-timed
module system_exception_power_control
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core handshake
    input wire logic insn_done,
    input wire logic irq_mask,
    input wire logic trap_insn,
    input wire logic wait_insn,
    input wire logic stop_insn,
    input wire logic return_insn,
    input wire logic [15:0] core_pc,
    output logic [3:0] vector,
    output logic [15:0] stack_pc,
    output logic stack_push,
    output logic mask_set,
    output logic mask_clear,
    output logic stack_upper_index,
    // Interrupt sources, bit 0 highest priority
    input wire logic [exc_pkg::NUM_IRQ-1:0] irq_req,
    input wire logic [exc_pkg::NUM_IRQ-1:0] irq_en,
    input wire logic break_req,
    // Reset sources
    input wire logic por_event,
    input wire logic pin_event,
    input wire logic wdog_event,
    input wire logic bad_op_event,
    input wire logic bad_addr_event,
    input wire logic low_vdd_event,
    // Clock gating and protection
    input wire logic crystal_fall,
    output logic core_clock_en,
    output logic periph_clock_en,
    output logic base_clock_en,
    output logic crystal_clock_en,
    output logic watchdog_run,
    output logic break_active,
    output logic flag_clear_allow
);

    exc_pkg::state_type cur;
    exc_pkg::state_type next_cur;

    logic [exc_pkg::NUM_IRQ-1:0] pending;
    logic any_reset;
    logic [2:0] win_idx;
    logic win_any;
    logic [11:0] rec_last;

    function automatic logic [3:0] pick(input logic [exc_pkg::NUM_IRQ-1:0] p);
        logic [3:0] r;
        r = {1'b0, exc_pkg::IRQ_NONE_IDX};
        for (int i = exc_pkg::NUM_IRQ - 1; i >= 0; i--)
        begin
            if (p[i])
            begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    always_comb
    begin
        pending = irq_req & irq_en;
        {win_any, win_idx} = pick(pending); // RULE3
        any_reset = por_event | pin_event | wdog_event | bad_op_event | bad_addr_event
            | low_vdd_event;
        rec_last = cur.short_wake_delay_bit ? exc_pkg::CNT_SHORT_LAST
            : exc_pkg::CNT_LONG_LAST; // RULE18
    end

    always_comb
    begin
        next_cur = cur;
        next_cur.push = 1'b0;
        next_cur.set_mask = 1'b0;
        next_cur.clr_mask = 1'b0;

        // Bus address phase capture
        if (hready)
        begin
            next_cur.ph.sel = hsel & htrans[1];
            next_cur.ph.addr = haddr[7:0];
            next_cur.ph.write = hwrite;
        end

        // Data phase: write and read effects
        if (cur.ph.sel)
        begin
            if (cur.ph.write)
            begin
                case (cur.ph.addr)
                    exc_pkg::ADDR_BREAK_WAIT:
                    begin
                        if (!hwdata[exc_pkg::BIT_BRK_WAIT])
                        begin
                            next_cur.break_exit_wait_flag = 1'b0; // RULE21
                        end
                    end
                    exc_pkg::ADDR_BREAK_CTRL:
                    begin
                        next_cur.break_flag_clear_enable = hwdata[exc_pkg::BIT_CLR_EN];
                    end
                    exc_pkg::ADDR_CONFIG:
                    begin
                        next_cur.short_wake_delay_bit = hwdata[exc_pkg::BIT_SHORT_WAKE];
                        next_cur.watchdog_disable_bit = hwdata[exc_pkg::BIT_WDOG_OFF];
                    end
                    default: ;
                endcase
            end
            else if (cur.ph.addr == exc_pkg::ADDR_RESET_SRC)
            begin
                next_cur.rsr = exc_pkg::BYTE_ZERO; // RULE22
            end
        end

        // Read data for the next data phase
        next_cur.rdata = '0;
        if (hready && hsel && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                exc_pkg::ADDR_BREAK_WAIT:
                begin
                    next_cur.rdata[exc_pkg::BIT_BRK_WAIT] = cur.break_exit_wait_flag;
                end
                exc_pkg::ADDR_RESET_SRC: next_cur.rdata[7:0] = cur.rsr;
                exc_pkg::ADDR_BREAK_CTRL:
                begin
                    next_cur.rdata[exc_pkg::BIT_CLR_EN] = cur.break_flag_clear_enable;
                end
                exc_pkg::ADDR_CONFIG:
                begin
                    next_cur.rdata[exc_pkg::BIT_SHORT_WAKE] = cur.short_wake_delay_bit;
                    next_cur.rdata[exc_pkg::BIT_WDOG_OFF] = cur.watchdog_disable_bit;
                end
                exc_pkg::ADDR_STATE: next_cur.rdata[2:0] = cur.mode;
                default: ;
            endcase
        end

        // Exception sequencing
        case (cur.mode)
            exc_pkg::RUN:
            begin
                if (break_req && !cur.break_state)
                begin
                    next_cur.latched = 1'b1; // RULE9
                    next_cur.trap = 1'b1;
                    next_cur.break_state = 1'b1;
                end
                else if (!cur.latched && insn_done)
                begin
                    if (trap_insn)
                    begin
                        next_cur.latched = 1'b1; // RULE6
                        next_cur.trap = 1'b1;
                    end
                    else if (win_any && !irq_mask)
                    begin
                        next_cur.latched = 1'b1; // RULE2
                        next_cur.trap = 1'b0;
                        next_cur.latched_idx = win_idx;
                    end
                    else if (wait_insn)
                    begin
                        next_cur.clr_mask = 1'b1; // RULE13
                        next_cur.mode = exc_pkg::WAITING;
                    end
                    else if (stop_insn)
                    begin
                        next_cur.clr_mask = 1'b1; // RULE13
                        next_cur.cnt_hold = 1'b1; // RULE19
                        next_cur.cnt = exc_pkg::CNT_ZERO;
                        next_cur.mode = exc_pkg::STOPPED;
                    end
                end
                if (cur.latched)
                begin
                    next_cur.mode = exc_pkg::STACKING;
                end
                if (return_insn)
                begin
                    next_cur.break_state = 1'b0;
                end
            end
            exc_pkg::WAITING:
            begin
                if (break_req)
                begin
                    next_cur.break_exit_wait_flag = 1'b1; // RULE15
                    next_cur.latched = 1'b1;
                    next_cur.trap = 1'b1;
                    next_cur.break_state = 1'b1;
                    next_cur.mode = exc_pkg::STACKING;
                end
                else if (win_any)
                begin
                    next_cur.latched = 1'b1; // RULE14
                    next_cur.trap = 1'b0;
                    next_cur.latched_idx = win_idx;
                    next_cur.mode = exc_pkg::STACKING;
                end
            end
            exc_pkg::STOPPED:
            begin
                next_cur.cnt = exc_pkg::CNT_ZERO; // RULE17
                if (win_any)
                begin
                    next_cur.latched = 1'b1;
                    next_cur.trap = 1'b0;
                    next_cur.latched_idx = win_idx;
                    next_cur.cnt_hold = 1'b0; // RULE19
                    next_cur.mode = exc_pkg::RECOVER;
                end
            end
            exc_pkg::RECOVER:
            begin
                if (crystal_fall)
                begin
                    next_cur.cnt = cur.cnt + 12'h001; // RULE23
                    if (cur.cnt == rec_last)
                    begin
                        next_cur.mode = exc_pkg::STACKING; // RULE18
                    end
                end
            end
            exc_pkg::STACKING:
            begin
                next_cur.push = 1'b1; // RULE4
                next_cur.set_mask = 1'b1;
                next_cur.vector = cur.trap ? exc_pkg::VEC_TRAP
                    : {1'b0, cur.latched_idx} + 4'h1;
                next_cur.ret_pc = cur.trap ? core_pc : core_pc - exc_pkg::PC_ONE; // RULE7
                next_cur.latched = 1'b0; // RULE1
                next_cur.mode = exc_pkg::RUN;
            end
            default: next_cur.mode = exc_pkg::RUN;
        endcase

        // Latched claim dropped only when unmasked before service
        if (cur.latched && !cur.trap && cur.mode == exc_pkg::RUN && !irq_mask && !win_any)
        begin
            next_cur.latched = 1'b0; // RULE1
        end

        // Resets win over everything except a mask clear from a same-cycle wait or stop; a pin reset keeps the counter
        if (any_reset)
        begin
            next_cur.mode = exc_pkg::RUN; // RULE8
            next_cur.latched = 1'b0;
            next_cur.trap = 1'b0;
            next_cur.break_state = 1'b0;
            next_cur.break_exit_wait_flag = 1'b0; // RULE21
            next_cur.break_flag_clear_enable = 1'b0;
            next_cur.push = 1'b0;
            next_cur.set_mask = 1'b0;
            next_cur.vector = exc_pkg::VEC_IDLE;
            if (por_event)
            begin
                next_cur.rsr = exc_pkg::BYTE_ZERO; // RULE22
                next_cur.rsr[exc_pkg::RS_POR] = 1'b1;
            end
            else
            begin
                // Built on next value so a same-cycle read still clears older bits
                next_cur.rsr[exc_pkg::RS_PIN] |= pin_event;
                next_cur.rsr[exc_pkg::RS_WDOG] |= wdog_event;
                next_cur.rsr[exc_pkg::RS_BAD_OP] |= bad_op_event;
                next_cur.rsr[exc_pkg::RS_BAD_ADDR] |= bad_addr_event;
                next_cur.rsr[exc_pkg::RS_LOW_VDD] |= low_vdd_event;
            end
            if (pin_event == 1'b0)
            begin
                next_cur.cnt = exc_pkg::CNT_ZERO;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.mode <= exc_pkg::RUN;
        end
        else if (clock_en)
        begin
            cur <= next_cur;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = cur.rdata;
    assign vector = cur.vector;
    assign stack_pc = cur.ret_pc;
    assign stack_push = cur.push;
    assign mask_set = cur.set_mask;
    assign mask_clear = cur.clr_mask;
    assign stack_upper_index = 1'b0; // RULE5
    assign core_clock_en = (cur.mode == exc_pkg::RUN) || (cur.mode == exc_pkg::STACKING); // RULE14
    assign periph_clock_en = (cur.mode != exc_pkg::STOPPED) && (cur.mode != exc_pkg::RECOVER);
    assign base_clock_en = (cur.mode != exc_pkg::STOPPED); // RULE17
    assign crystal_clock_en = (cur.mode != exc_pkg::STOPPED);
    assign watchdog_run = !cur.watchdog_disable_bit && (cur.mode != exc_pkg::STOPPED); // RULE16
    assign break_active = cur.break_state && (cur.mode != exc_pkg::STOPPED); // RULE20
    // Two-step sequences in peripherals gate on this level, so protection holds
    assign flag_clear_allow = !cur.break_state
        || cur.break_flag_clear_enable; // RULE10 RULE11 RULE12

    AST_HW_PC_MINUS_ONE: assert property (@(posedge clock) disable iff (rst) // RULE7
        (clock_en && cur.mode == exc_pkg::STACKING && !cur.trap)
        |=> stack_pc == $past(core_pc) - exc_pkg::PC_ONE)
        else $error("hardware return address not pc minus one");
    AST_TRAP_VECTOR: assert property (@(posedge clock) disable iff (rst) // RULE9
        (clock_en && cur.mode == exc_pkg::RUN && break_req && !cur.break_state && !any_reset)
        |=> cur.trap && cur.latched)
        else $error("break did not force trap");
    AST_PUSH_SETS_MASK: assert property (@(posedge clock) disable iff (rst) // RULE4
        stack_push |-> mask_set)
        else $error("stacking without mask set");
    AST_NO_UPPER_INDEX: assert property (@(posedge clock) disable iff (rst) // RULE5
        !stack_upper_index)
        else $error("upper index stacked");
    AST_RESET_WINS: assert property (@(posedge clock) disable iff (rst) // RULE8
        (clock_en && any_reset) |=> cur.mode == exc_pkg::RUN && !stack_push)
        else $error("reset did not override interrupt");
    AST_BREAK_WAIT: assert property (@(posedge clock) disable iff (rst) // RULE15
        (clock_en && cur.mode == exc_pkg::WAITING && break_req && !any_reset)
        |=> cur.break_exit_wait_flag)
        else $error("break in wait did not set flag");
    AST_FLAG_PROTECT: assert property (@(posedge clock) disable iff (rst) // RULE10
        (cur.break_state && !cur.break_flag_clear_enable) |-> !flag_clear_allow)
        else $error("flags clearable in break");
    AST_STOP_CLOCKS: assert property (@(posedge clock) disable iff (rst) // RULE17
        cur.mode == exc_pkg::STOPPED |-> !base_clock_en && !crystal_clock_en && !core_clock_en)
        else $error("clocks running in stop");
    AST_WAIT_CLOCKS: assert property (@(posedge clock) disable iff (rst) // RULE14
        cur.mode == exc_pkg::WAITING |-> !core_clock_en && periph_clock_en)
        else $error("wait clock gating wrong");
    AST_POR_ONLY: assert property (@(posedge clock) disable iff (rst) // RULE22
        (clock_en && por_event) |=> cur.rsr == 8'h80)
        else $error("power-on did not clear other flags");
    AST_WDOG: assert property (@(posedge clock) disable iff (rst) // RULE16
        (cur.mode == exc_pkg::WAITING && !cur.watchdog_disable_bit) |-> watchdog_run)
        else $error("watchdog stopped in wait");

    COV_WAIT_WAKE: cover property (@(posedge clock)
        cur.mode == exc_pkg::WAITING ##1 cur.mode == exc_pkg::STACKING);
    COV_STOP_RECOVER: cover property (@(posedge clock)
        cur.mode == exc_pkg::RECOVER ##1 cur.mode == exc_pkg::STACKING);
    COV_BREAK: cover property (@(posedge clock) cur.break_state && cur.break_flag_clear_enable);
endmodule

// ---- verification/core_model.sv ----
module core_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bench requests: 0 plain, 1 trap, 2 wait, 3 stop, 4 return
    input wire logic step,
    input wire logic [2:0] kind,
    input wire logic slow,
    // Exception unit answers
    input wire logic mask_set,
    input wire logic mask_clear,
    // Core side
    output logic insn_done,
    output logic trap_insn,
    output logic wait_insn,
    output logic stop_insn,
    output logic return_insn,
    output logic irq_mask,
    output logic [15:0] core_pc
);
    timeunit 1ns;
    timeprecision 1ps;

    logic busy;
    logic [1:0] cnt;
    logic [2:0] op;

    always_ff @(posedge clock)
    begin
        insn_done <= 1'b0;
        trap_insn <= 1'b0;
        wait_insn <= 1'b0;
        stop_insn <= 1'b0;
        return_insn <= 1'b0;
        if (rst)
        begin
            busy <= 1'b0;
            cnt <= 2'h0;
            op <= 3'h0;
            irq_mask <= 1'b0;
            core_pc <= 16'h0100;
        end
        else
        begin
            if (mask_set)
                irq_mask <= 1'b1;
            if (mask_clear)
                irq_mask <= 1'b0;
            if (step)
            begin
                busy <= 1'b1;
                cnt <= slow ? 2'h3 : 2'h0;
                op <= kind;
            end
            else if (busy && cnt != 2'h0)
                cnt <= cnt - 2'h1;
            else if (busy)
            begin
                // PC already points past the finished instruction
                busy <= 1'b0;
                insn_done <= 1'b1;
                trap_insn <= (op == 3'h1);
                wait_insn <= (op == 3'h2);
                stop_insn <= (op == 3'h3);
                return_insn <= (op == 3'h4);
                core_pc <= core_pc + 16'h0001;
                // Unstacked mask was clear in every case this bench builds but the third trap, taken while masked
                if (op == 3'h4)
                    irq_mask <= 1'b0;
            end
        end
    end
endmodule

// ---- verification/system_exception_power_control_tb_top.sv ----
module system_exception_power_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] req;
        logic [7:0] en;
        logic [7:0] late;
        logic [2:0] kind;
        logic [3:0] vec;
    } row_type;

    // Late requests arrive after the boundary and must not displace the latched one
    localparam row_type ROWS [6] = '{
        '{8'h01, 8'hFF, 8'h00, 3'h0, 4'h1},
        '{8'h06, 8'hFF, 8'h00, 3'h0, 4'h2},
        '{8'h04, 8'hFF, 8'h00, 3'h0, 4'h3},
        '{8'h80, 8'hFF, 8'h01, 3'h0, 4'h8},
        '{8'h0C, 8'h08, 8'h00, 3'h0, 4'h4},
        '{8'h00, 8'h00, 8'h00, 3'h1, 4'hF}};
    localparam logic [7:0] SRC [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
    localparam logic [7:0] RADDR [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h20};

    logic clock, rst, clock_en, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, kind;
    wire logic hready;
    logic step, slow, break_req, crystal_fall;
    logic insn_done, irq_mask, trap_insn, wait_insn, stop_insn, return_insn;
    logic [15:0] core_pc, stack_pc, pc;
    logic [3:0] vector;
    logic stack_push, mask_set, mask_clear, stack_upper_index;
    logic [7:0] irq_req, irq_en;
    logic [5:0] ev;
    logic por_event, pin_event, wdog_event, bad_op_event, bad_addr_event, low_vdd_event;
    logic core_clock_en, periph_clock_en, base_clock_en, crystal_clock_en;
    logic watchdog_run, break_active, flag_clear_allow;
    int fail_count, n_compared, cycles, pushes;

    assign hready = hreadyout;
    assign {por_event, pin_event, wdog_event, bad_op_event, bad_addr_event, low_vdd_event} = ev;

    system_exception_power_control uut (.*);
    core_model core (.*);

    initial clock = 1'b0;
    always #4 clock = ~clock;

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (stack_push === 1'b1)
            pushes <= pushes + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Single AHB transfer; no wait count assumed, the cycle ceiling cuts a hang
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask

    task automatic ins(input logic [2:0] k);
        step <= 1'b1;
        kind <= k;
        @(posedge clock);
        step <= 1'b0;
        while (insn_done !== 1'b1) @(posedge clock);
        pc = core_pc;
    endtask

    task automatic wpush(input int lim);
        int i;
        i = 0;
        while (stack_push !== 1'b1 && i < lim)
        begin
            @(posedge clock);
            i++;
        end
        chk(stack_push, 32'h1);
    endtask

    task automatic xtal(input int n);
        repeat (n)
        begin
            crystal_fall <= 1'b1;
            @(posedge clock);
            crystal_fall <= 1'b0;
            @(posedge clock);
        end
    endtask

    task automatic stop_case(input logic sh, input int n);
        int k;
        k = pushes;
        bus(1'b1, exc_pkg::ADDR_CONFIG, {31'h00000000, sh});
        ins(3'h3);
        repeat (2) @(posedge clock);
        chk(base_clock_en, 32'h0);
        chk(crystal_clock_en, 32'h0);
        // Falls before the wake request must not count
        xtal(5);
        irq_req <= 8'h01;
        @(posedge clock);
        xtal(n - 1);
        chk(pushes - k, 32'h0);
        xtal(1);
        wpush(6);
        chk(vector, 32'h1);
        irq_req <= 8'h00;
        ins(3'h4);
    endtask

    initial
    begin
        rst = 1'b1;
        clock_en = 1'b1;
        {hsel, hwrite, step, slow, break_req, crystal_fall} = 6'h00;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'h0;
        hsize = 3'h2;
        kind = 3'h0;
        irq_req = 8'h00;
        irq_en = 8'h00;
        ev = 6'h00;
        {fail_count, n_compared, cycles, pushes} = 128'h0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        bus(1'b1, 8'h20, 32'h000000FF);
        foreach (RADDR[i])
        begin
            bus(1'b0, RADDR[i], 32'h0);
            chk(rd, 32'h0);
        end
        chk(hresp, 32'h0);
        chk(flag_clear_allow, 32'h1);
        foreach (ROWS[i])
        begin
            irq_en <= ROWS[i].en;
            irq_req <= ROWS[i].req;
            slow <= i[0];
            ins(ROWS[i].kind);
            irq_req <= ROWS[i].req | ROWS[i].late;
            wpush(20);
            chk(vector, ROWS[i].vec);
            chk(stack_pc, ROWS[i].kind == 3'h1 ? pc : pc - 16'h0001);
            chk(mask_set, 32'h1);
            chk(stack_upper_index, 32'h0);
            irq_req <= 8'h00;
            ins(3'h4);
        end
        // Masked core: plain boundary must not enter, trap still must
        ins(3'h1);
        wpush(20);
        irq_en <= 8'hFF;
        irq_req <= 8'h01;
        // Let the trap's push land in the count first
        @(posedge clock);
        rd = pushes;
        ins(3'h0);
        repeat (6) @(posedge clock);
        chk(pushes - rd, 32'h0);
        irq_req <= 8'h00;
        ins(3'h1);
        wpush(20);
        chk(vector, exc_pkg::VEC_TRAP);
        ins(3'h4);
        ins(3'h2);
        repeat (2) @(posedge clock);
        chk(irq_mask, 32'h0);
        chk(core_clock_en, 32'h0);
        chk(periph_clock_en, 32'h1);
        chk(watchdog_run, 32'h1);
        bus(1'b0, exc_pkg::ADDR_STATE, 32'h0);
        chk(rd, 32'h1);
        irq_req <= 8'h10;
        wpush(4);
        chk(vector, 32'h5);
        irq_req <= 8'h00;
        ins(3'h4);
        ins(3'h2);
        break_req <= 1'b1;
        wpush(8);
        chk(vector, exc_pkg::VEC_TRAP);
        chk(break_active, 32'h1);
        chk(flag_clear_allow, 32'h0);
        bus(1'b0, exc_pkg::ADDR_BREAK_WAIT, 32'h0);
        chk(rd, 32'h1);
        bus(1'b1, exc_pkg::ADDR_BREAK_CTRL, 32'h00000080);
        @(posedge clock);
        chk(flag_clear_allow, 32'h1);
        bus(1'b1, exc_pkg::ADDR_BREAK_WAIT, 32'h0);
        bus(1'b0, exc_pkg::ADDR_BREAK_WAIT, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, exc_pkg::ADDR_BREAK_CTRL, 32'h0);
        break_req <= 1'b0;
        ins(3'h4);
        @(posedge clock);
        chk(break_active, 32'h0);
        bus(1'b0, exc_pkg::ADDR_BREAK_WAIT, 32'h0);
        chk(rd, 32'h0);
        stop_case(1'b1, 32);
        stop_case(1'b0, 4096);
        // Flush whatever power-up left in the source flags
        bus(1'b0, exc_pkg::ADDR_RESET_SRC, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            ev <= (i == 6) ? 6'h11 : 6'h20 >> i;
            @(posedge clock);
            ev <= 6'h00;
            repeat (2) @(posedge clock);
            bus(1'b0, exc_pkg::ADDR_RESET_SRC, 32'h0);
            chk(rd, (i == 6) ? 32'h42 : {24'h000000, SRC[i]});
        end
        bus(1'b0, exc_pkg::ADDR_RESET_SRC, 32'h0);
        chk(rd, 32'h0);
        ev <= 6'h10;
        @(posedge clock);
        ev <= 6'h20;
        @(posedge clock);
        ev <= 6'h00;
        repeat (2) @(posedge clock);
        bus(1'b0, exc_pkg::ADDR_RESET_SRC, 32'h0);
        chk(rd, 32'h80);
        bus(1'b1, exc_pkg::ADDR_CONFIG, 32'h3);
        @(posedge clock);
        chk(watchdog_run, 32'h0);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, exc_pkg::ADDR_CONFIG, 32'h0);
        chk(rd, 32'h0);
        results();
    end
endmodule
